// >>> tmd_pkg.sv
// Purpose: Constants and types for the touch discharge configuration block
// Assumes: 32-bit register words on a plain strobe port
// Notes: Register offsets are byte addresses
//
// What this block does
// - Sources and reference on only while enabled
// - Reference select: band gap or supply fraction
// - Internal resistor or external resistor pin
// - Current scaled by trim field
// - Mirror current onto masked Y pins only
// - Comparators may power down when idle
// - Comparators always on when control zero
// - Stop discharge on a set count of positives in the last five samples
// - Consensus zero stops on first positive
// - Cx discharge lasts discharge-length prescaler cycles
// - Twelve-bit spacing from Cx discharge end to next X-line start
// - Sync falling edge triggers acquisition
`default_nettype none

package tmd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_Y = 16;
  localparam int unsigned NUM_X = 8;
  localparam int unsigned CONS_WIN = 5;

  localparam logic [7:0] DSC_OFFSET = 8'h34;
  localparam logic [7:0] MGC2_OFFSET = 8'h38;
  localparam logic [7:0] CTL_OFFSET = 8'h3C;
  localparam logic [7:0] STAT_OFFSET = 8'h40;

  localparam logic [31:0] DSC_RESET = 32'h00000000;
  localparam logic [31:0] MGC2_RESET = 32'h00000000;
  localparam logic [31:0] CTL_RESET = 32'h00000000;

  // Discharge source control fields
  localparam int unsigned DISCHARGE_GLOBAL_ENABLE_BIT = 0;
  localparam int unsigned VREF_BIT = 1;
  localparam int unsigned RINT_BIT = 2;
  localparam int unsigned TRIM_LSB = 8;
  localparam int unsigned TRIM_W = 8;
  localparam int unsigned SRC_LSB = 16;

  // Matrix group config two fields
  localparam int unsigned ACC_BIT = 31;
  localparam int unsigned CONS_LSB = 28;
  localparam int unsigned CONS_W = 3;
  localparam int unsigned CXD_LSB = 16;
  localparam int unsigned CXD_W = 8;
  localparam int unsigned SYNCT_LSB = 0;
  localparam int unsigned SYNCT_W = 12;

  // Control register fields
  localparam int unsigned START_BIT = 0;
  localparam int unsigned SYNCEN_BIT = 1;
  localparam int unsigned PSC_LSB = 8;
  localparam int unsigned PSC_W = 8;

  typedef struct packed {
    logic discharge_global_enable;
    logic reference_voltage_select;
    logic internal_resistor_select;
    logic [7:0] trim;
    logic [15:0] sources;
  } tmd_dsc_t;

  typedef struct packed {
    logic comparator_power_control;
    logic [2:0] consensus_count;
    logic [7:0] cx_discharge_length;
    logic [11:0] x_line_spacing_interval;
  } tmd_mgc2_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_BURST = 5'h04,
    ST_CXDIS = 5'h08,
    ST_SPACE = 5'h10
  } tmd_state_t;
endpackage

`default_nettype wire

// >>> tmd_consensus.sv
// Purpose: Consensus filter over the last five comparator samples
// Assumes: Sample enable from the burst prescaler domain logic
// Notes: History clears on start of each discharge
`default_nettype none

module tmd_consensus (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic sample_en_i,
  input wire logic cmp_i,
  input wire logic [2:0] count_i,
  output logic done_o
);
  logic [4:0] hist_r;
  logic [4:0] hist_nxt;
  logic [2:0] ones;

  always_comb begin
    hist_nxt = hist_r;
    if (clear_i) begin
      hist_nxt = '0;
    end else if (sample_en_i) begin
      hist_nxt = {hist_r[3:0], cmp_i};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hist_r <= '0;
    end else begin
      hist_r <= hist_nxt;
    end
  end

  always_comb begin
    ones = '0;
    for (int i = 0; i < 5; i++) begin
      ones = ones + {2'b00, hist_r[i]};
    end
    if (count_i == 3'h0) begin
      done_o = hist_r[0];
    end else begin
      done_o = (ones >= count_i);
    end
  end
endmodule

`default_nettype wire

// >>> tmd_top.sv
// Purpose: Discharge source control and matrix acquisition timing
// Assumes: 20 MHz clock, asynchronous sync and comparator inputs
// Notes: Analog parts sit outside; this block drives their controls
`default_nettype none

module tmd_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic cmp_i,
  input wire logic sync_i,
  output logic src_en_o,
  output logic vref_en_o,
  output logic vref_sel_o,
  output logic rint_sel_o,
  output logic rpin_en_o,
  output logic [7:0] trim_o,
  output logic [15:0] y_src_o,
  output logic cmp_en_o,
  output logic cx_dis_o,
  output logic burst_o,
  output logic [2:0] x_line_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  tmd_pkg::tmd_dsc_t dsc_r, dsc_nxt;
  tmd_pkg::tmd_mgc2_t mgc_r, mgc_nxt;
  logic syncen_r, syncen_nxt;
  logic [7:0] psc_r, psc_nxt;
  logic start_nxt;
  logic [31:0] rd_nxt;
  logic [31:0] dsc_word;
  logic [31:0] mgc_word;
  logic [31:0] ctl_word;
  logic [31:0] stat_word;

  assign dsc_word = {dsc_r.sources, dsc_r.trim, 5'h00, dsc_r.internal_resistor_select,
                     dsc_r.reference_voltage_select, dsc_r.discharge_global_enable};
  assign mgc_word = {mgc_r.comparator_power_control, mgc_r.consensus_count, 4'h0,
                     mgc_r.cx_discharge_length, 4'h0, mgc_r.x_line_spacing_interval};

  // ----------------------------------------
  // Synchronisers and sync edge
  // ----------------------------------------
  logic cmp_s1_r, cmp_s2_r, sync_s1_r, sync_s2_r, sync_d_r;
  logic sync_fall;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      sync_s1_r <= 1'b1;
      sync_s2_r <= 1'b1;
      sync_d_r <= 1'b1;
    end else begin
      cmp_s1_r <= cmp_i;
      cmp_s2_r <= cmp_s1_r;
      sync_s1_r <= sync_i;
      sync_s2_r <= sync_s1_r;
      sync_d_r <= sync_s2_r;
    end
  end

  assign sync_fall = sync_d_r & ~sync_s2_r;

  // ----------------------------------------
  // Burst prescaler
  // ----------------------------------------
  logic [7:0] pcnt_r, pcnt_nxt;
  logic tick;

  assign tick = (pcnt_r == psc_r);

  always_comb begin
    pcnt_nxt = tick ? 8'h00 : pcnt_r + 8'h01;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pcnt_r <= 8'h00;
    end else begin
      pcnt_r <= pcnt_nxt;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  tmd_pkg::tmd_state_t st_r, st_nxt;

  always_comb begin
    dsc_nxt = dsc_r;
    mgc_nxt = mgc_r;
    syncen_nxt = syncen_r;
    psc_nxt = psc_r;
    start_nxt = 1'b0;
    rd_nxt = 32'h00000000;
    ctl_word = {16'h0000, psc_r, 6'h00, syncen_r, 1'b0};
    stat_word = {24'h000000, 3'h0, st_r};
    if (wr_i) begin
      case (addr_i)
        tmd_pkg::DSC_OFFSET: begin
          dsc_nxt.discharge_global_enable = wdata_i[tmd_pkg::DISCHARGE_GLOBAL_ENABLE_BIT];
          dsc_nxt.reference_voltage_select = wdata_i[tmd_pkg::VREF_BIT];
          dsc_nxt.internal_resistor_select = wdata_i[tmd_pkg::RINT_BIT];
          dsc_nxt.trim = wdata_i[tmd_pkg::TRIM_LSB +: tmd_pkg::TRIM_W];
          dsc_nxt.sources = wdata_i[tmd_pkg::SRC_LSB +: tmd_pkg::NUM_Y];
        end
        tmd_pkg::MGC2_OFFSET: begin
          mgc_nxt.comparator_power_control = wdata_i[tmd_pkg::ACC_BIT];
          mgc_nxt.consensus_count = wdata_i[tmd_pkg::CONS_LSB +: tmd_pkg::CONS_W];
          mgc_nxt.cx_discharge_length = wdata_i[tmd_pkg::CXD_LSB +: tmd_pkg::CXD_W];
          mgc_nxt.x_line_spacing_interval = wdata_i[tmd_pkg::SYNCT_LSB +: tmd_pkg::SYNCT_W];
        end
        tmd_pkg::CTL_OFFSET: begin
          start_nxt = wdata_i[tmd_pkg::START_BIT];
          syncen_nxt = wdata_i[tmd_pkg::SYNCEN_BIT];
          psc_nxt = wdata_i[tmd_pkg::PSC_LSB +: tmd_pkg::PSC_W];
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        tmd_pkg::DSC_OFFSET: rd_nxt = dsc_word;
        tmd_pkg::MGC2_OFFSET: rd_nxt = mgc_word;
        tmd_pkg::CTL_OFFSET: rd_nxt = ctl_word;
        tmd_pkg::STAT_OFFSET: rd_nxt = stat_word;
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dsc_r <= tmd_pkg::DSC_RESET[26:0];
      mgc_r <= tmd_pkg::MGC2_RESET[23:0];
      syncen_r <= tmd_pkg::CTL_RESET[tmd_pkg::SYNCEN_BIT];
      psc_r <= tmd_pkg::CTL_RESET[tmd_pkg::PSC_LSB +: tmd_pkg::PSC_W];
    end else begin
      dsc_r <= dsc_nxt;
      mgc_r <= mgc_nxt;
      syncen_r <= syncen_nxt;
      psc_r <= psc_nxt;
    end
  end

  // ----------------------------------------
  // Acquisition sequencer
  // ----------------------------------------
  logic [11:0] cnt_r, cnt_nxt;
  logic [2:0] xl_r, xl_nxt;
  logic cons_done;
  logic cons_clear;
  logic in_burst;

  assign in_burst = (st_r == tmd_pkg::ST_BURST);
  assign cons_clear = (st_r != tmd_pkg::ST_BURST);

  tmd_consensus u_cons (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(cons_clear),
    .sample_en_i(in_burst & tick),
    .cmp_i(cmp_s2_r),
    .count_i(mgc_r.consensus_count),
    .done_o(cons_done)
  );

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    xl_nxt = xl_r;
    case (st_r)
      tmd_pkg::ST_IDLE: begin
        if (start_nxt) begin
          xl_nxt = 3'h0;
          st_nxt = syncen_r ? tmd_pkg::ST_WAIT : tmd_pkg::ST_BURST;
        end
      end
      tmd_pkg::ST_WAIT: begin
        if (sync_fall) begin
          st_nxt = tmd_pkg::ST_BURST;
        end
      end
      tmd_pkg::ST_BURST: begin
        if (cons_done) begin
          st_nxt = tmd_pkg::ST_CXDIS;
          cnt_nxt = {4'h0, mgc_r.cx_discharge_length};
        end
      end
      tmd_pkg::ST_CXDIS: begin
        if (cnt_r == 12'h000) begin
          if (xl_r == 3'(tmd_pkg::NUM_X - 1)) begin
            st_nxt = tmd_pkg::ST_IDLE;
          end else if (mgc_r.x_line_spacing_interval == 12'h000) begin
            xl_nxt = xl_r + 3'h1;
            st_nxt = tmd_pkg::ST_BURST;
          end else begin
            cnt_nxt = mgc_r.x_line_spacing_interval;
            st_nxt = tmd_pkg::ST_SPACE;
          end
        end else if (tick) begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      tmd_pkg::ST_SPACE: begin
        if (cnt_r == 12'h000) begin
          xl_nxt = xl_r + 3'h1;
          st_nxt = tmd_pkg::ST_BURST;
        end else if (tick) begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      default: st_nxt = tmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= tmd_pkg::ST_IDLE;
      cnt_r <= 12'h000;
      xl_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      xl_r <= xl_nxt;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_en_o <= 1'b0;
      vref_en_o <= 1'b0;
      vref_sel_o <= 1'b0;
      rint_sel_o <= 1'b0;
      rpin_en_o <= 1'b0;
      trim_o <= 8'h00;
      y_src_o <= 16'h0000;
      cmp_en_o <= 1'b1;
      cx_dis_o <= 1'b0;
      burst_o <= 1'b0;
      x_line_o <= 3'h0;
      rdata_o <= 32'h00000000;
    end else begin
      src_en_o <= dsc_nxt.discharge_global_enable;
      vref_en_o <= dsc_nxt.discharge_global_enable;
      vref_sel_o <= dsc_nxt.reference_voltage_select;
      rint_sel_o <= dsc_nxt.discharge_global_enable & dsc_nxt.internal_resistor_select;
      rpin_en_o <= dsc_nxt.discharge_global_enable & ~dsc_nxt.internal_resistor_select;
      trim_o <= dsc_nxt.trim;
      y_src_o <= dsc_nxt.discharge_global_enable ? dsc_nxt.sources : 16'h0000;
      // Idle comparators off only when power control allows
      cmp_en_o <= ~mgc_nxt.comparator_power_control | (st_nxt == tmd_pkg::ST_BURST);
      cx_dis_o <= (st_nxt == tmd_pkg::ST_CXDIS);
      burst_o <= (st_nxt == tmd_pkg::ST_BURST);
      x_line_o <= xl_nxt;
      rdata_o <= rd_nxt;
    end
  end
endmodule

`default_nettype wire

// >>> tmd_props.sv
// Purpose: Port properties of the discharge block
// Assumes: One clock, async active-high reset
// Notes: Bound to every tmd_top
`default_nettype none
module tmd_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic cmp_i,
  input wire logic src_en_o,
  input wire logic vref_en_o,
  input wire logic vref_sel_o,
  input wire logic rint_sel_o,
  input wire logic rpin_en_o,
  input wire logic [7:0] trim_o,
  input wire logic [15:0] y_src_o,
  input wire logic cmp_en_o,
  input wire logic cx_dis_o,
  input wire logic burst_o,
  input wire logic [2:0] x_line_o
);
  logic acc_r;
  logic [2:0] cons_r;
  logic [7:0] psc_r;
  logic [11:0] sp_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r <= 1'b0;
      cons_r <= 3'h0;
      psc_r <= 8'h00;
      sp_r <= 12'h000;
    end else if (wr_i && addr_i == tmd_pkg::MGC2_OFFSET) begin
      acc_r <= wdata_i[31];
      cons_r <= wdata_i[30:28];
      sp_r <= wdata_i[11:0];
    end else if (wr_i && addr_i == tmd_pkg::CTL_OFFSET) begin
      psc_r <= wdata_i[15:8];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_dsc_wr;
    wr_i && addr_i == tmd_pkg::DSC_OFFSET ##2 1'b1;
  endsequence
  sequence s_cmp_hi;
    (burst_o && cmp_i && cons_r == 3'h0 && psc_r == 8'h00)[*3];
  endsequence
  AST_EN: assert property (s_dsc_wr |-> src_en_o == $past(wdata_i[0], 2))
    else $error("enable wrong");
  AST_VREF: assert property (vref_en_o == src_en_o)
    else $error("reference enable wrong");
  AST_VSEL: assert property (s_dsc_wr |-> vref_sel_o == $past(wdata_i[1], 2))
    else $error("reference select wrong");
  AST_RSEL: assert property ((rint_sel_o | rpin_en_o) == src_en_o && !(rint_sel_o && rpin_en_o))
    else $error("resistor select wrong");
  AST_TRIM: assert property (s_dsc_wr |-> trim_o == $past(wdata_i[15:8], 2))
    else $error("trim wrong");
  AST_YSRC: assert property (s_dsc_wr |->
    y_src_o == ($past(wdata_i[0], 2) ? $past(wdata_i[31:16], 2) : 16'h0000))
    else $error("source mask wrong");
  AST_CMP_ON: assert property (!acc_r ##1 !acc_r |-> cmp_en_o)
    else $error("comparator off");
  AST_CONS: assert property (s_cmp_hi |=> !burst_o)
    else $error("discharge not ended");
  AST_SPACE: assert property ($fell(cx_dis_o) && sp_r > 12'h001 |-> !burst_o [*2])
    else $error("spacing skipped");
  AST_NOSPACE: assert property ($fell(cx_dis_o) && sp_r == 12'h000 &&
    $past(x_line_o) != 3'h7 |-> ##[0:4] burst_o)
    else $error("next line late");
  AST_UNMAP: assert property (rd_i && !(addr_i inside {8'h34, 8'h38, 8'h3C, 8'h40})
    |=> rdata_o == 32'h00000000)
    else $error("unmapped read nonzero");
endmodule
bind tmd_top tmd_props tmd_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .cmp_i(cmp_i), .src_en_o(src_en_o), .vref_en_o(vref_en_o), .vref_sel_o(vref_sel_o),
  .rint_sel_o(rint_sel_o), .rpin_en_o(rpin_en_o), .trim_o(trim_o), .y_src_o(y_src_o),
  .cmp_en_o(cmp_en_o), .cx_dis_o(cx_dis_o), .burst_o(burst_o), .x_line_o(x_line_o));
`default_nettype wire

// >>> tmd_sense_model.sv
// Purpose: Comparator model facing the block
// Assumes: Trips a set delay after burst start
// Notes: Disabled comparator chatters
`default_nettype none
module tmd_sense_model (
  input wire logic clk_i,
  input wire logic burst_i,
  input wire logic cmp_en_i,
  input wire logic [3:0] dly_i,
  input wire logic noisy_i,
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r = 4'h0;
  logic ph_r = 1'b0;
  always @(posedge clk_i) begin
    ph_r <= ~ph_r;
    if (!burst_i)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hF)
      cnt_r <= cnt_r + 4'h1;
  end
  always_comb begin
    if (!cmp_en_i)
      cmp_o = ph_r;
    else
      cmp_o = burst_i && cnt_r >= dly_i && (!noisy_i || ph_r);
  end
endmodule
`default_nettype wire

// >>> tb_touch_matrix_discharge_config.sv
// Purpose: Self-checking bench for the discharge block
// Assumes: 20 MHz clock, strobe register port
// Notes: Reads checked from an expectation queue
`default_nettype none
module tb_touch_matrix_discharge_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sync_i = 1'b1;
  logic noisy = 1'b0, rd_d = 1'b0, bu_d = 1'b0, cmp_i;
  logic [3:0] dly = 4'h2;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000, rdata_o, m;
  logic src_en_o, vref_en_o, vref_sel_o, rint_sel_o, rpin_en_o, cmp_en_o, cx_dis_o, burst_o;
  logic [7:0] trim_o;
  logic [15:0] y_src_o;
  logic [2:0] x_line_o;
  logic [31:0] exq[$], mkq[$];
  int num_errors = 0, tests_run = 0, bursts = 0, len = 0, last_len = 0;
  tmd_top tmd_top_inst (.clk_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_i(cmp_i),
    .sync_i(sync_i), .src_en_o(src_en_o), .vref_en_o(vref_en_o), .vref_sel_o(vref_sel_o),
    .rint_sel_o(rint_sel_o), .rpin_en_o(rpin_en_o), .trim_o(trim_o), .y_src_o(y_src_o),
    .cmp_en_o(cmp_en_o), .cx_dis_o(cx_dis_o), .burst_o(burst_o), .x_line_o(x_line_o));
  tmd_sense_model tmd_sense_model_inst (.clk_i(clock_i), .burst_i(burst_o),
    .cmp_en_i(cmp_en_o), .dly_i(dly), .noisy_i(noisy), .cmp_o(cmp_i));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task finish_test;
    $display("Errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    exq.push_back(e);
    mkq.push_back(k);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task dsc(input logic [31:0] d);
    wr(tmd_pkg::DSC_OFFSET, d);
    rd(tmd_pkg::DSC_OFFSET, d & 32'hFFFFFF07, 32'hFFFFFFFF);
    chk("en", 32'({src_en_o, vref_en_o}), 32'({2{d[0]}}));
    chk("vsel", 32'(vref_sel_o), 32'(d[1]));
    chk("rsel", 32'({rint_sel_o, rpin_en_o}), 32'({d[0] & d[2], d[0] & ~d[2]}));
    chk("trim", 32'(trim_o), 32'(d[15:8]));
    chk("ysrc", 32'(y_src_o), d[0] ? 32'(d[31:16]) : 32'h00000000);
  endtask
  task acq(input logic [2:0] c, input logic [7:0] x, input logic [11:0] s,
           input logic [7:0] p, input logic y, input logic n);
    int i;
    noisy <= n;
    dly <= 4'($urandom_range(2, 9));
    wr(tmd_pkg::MGC2_OFFSET, {1'b1, c, 4'h0, x, 4'h0, s});
    bursts = 0;
    wr(tmd_pkg::CTL_OFFSET, {16'h0000, p, 6'h00, y, 1'b1});
    if (y) begin
      repeat (20) @(posedge clock_i);
      chk("hold", 32'(burst_o), 32'h00000000);
      sync_i <= 1'b0;
      for (i = 0; i < 10 && !burst_o; i++) @(posedge clock_i);
      chk("sync", 32'(burst_o), 32'h00000001);
      sync_i <= 1'b1;
    end
    for (i = 0; i < 5000 && (bursts < 8 || burst_o || cx_dis_o); i++) @(posedge clock_i);
    repeat (3) @(posedge clock_i);
    chk("lines", 32'(bursts), 32'h00000008);
    chk("cxlen", 32'(last_len), 32'(x) * (32'(p) + 1) + 32'(p == 8'h00));
    chk("cmpoff", 32'(cmp_en_o), 32'h00000000);
    rd(tmd_pkg::STAT_OFFSET, 32'h00000001, 32'h0000001F);
  endtask
  always @(posedge clock_i) begin
    rd_d <= rd_i;
    bu_d <= burst_o;
    if (rd_d && exq.size() > 0)
      chk("rdata", rdata_o & mkq.pop_front(), exq.pop_front());
    if (burst_o && !bu_d)
      bursts++;
    if (cx_dis_o)
      len++;
    else if (len > 0) begin
      last_len = len;
      len = 0;
    end
  end
  initial begin
    #1000000;
    num_errors++;
    $display("CHECK FAILED watchdog exp done got hang");
    finish_test;
  end
  initial begin
    void'($urandom(88459));
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    chk("cmprst", 32'(cmp_en_o), 32'h00000001);
    rd(tmd_pkg::MGC2_OFFSET, 32'h00000000, 32'hFFFFFFFF);
    rd(8'h50, 32'h00000000, 32'hFFFFFFFF);
    dsc(32'h00000000);
    repeat (6) dsc($urandom);
    dsc(32'hFFFFFFFF);
    repeat (4) begin
      m = $urandom;
      wr(tmd_pkg::MGC2_OFFSET, m);
      wr(8'h50, ~m);
      rd(tmd_pkg::MGC2_OFFSET, m & 32'hF0FF0FFF, 32'hF0FF0FFF);
    end
    acq(3'h0, 8'h03, 12'h000, 8'h00, 1'b0, 1'b0);
    acq(3'h3, 8'h05, 12'h000, 8'h00, 1'b0, 1'b1);
    acq(3'h0, 8'h02, 12'h005, 8'h02, 1'b1, 1'b0);
    wr(tmd_pkg::MGC2_OFFSET, 32'h00000000);
    @(posedge clock_i);
    chk("cmpon", 32'(cmp_en_o), 32'h00000001);
    finish_test;
  end
endmodule
`default_nettype wire
